// ### design/mirq_defs.svh
// Constants for the meter interrupt and temperature block
`ifndef MIRQ_DEFS_SVH
`define MIRQ_DEFS_SVH
// ---------------------------------------------------------------------
// Contract
// - Any event sets its own status flag
// - Enabled set flag drives request pin low
// - Flags set whatever the enable bits say
// - Read at 0Ch returns flags, then clears
// - Events during read-clear stay pending
// - Read-clear releases request after command byte
// - Request held high until status shifted out
// - After transfer, request returns if enabled pending
// - Mode bit 5 arms temperature at crossing
// - Route sensor, result after 24 slow cycles
// - Conversion done raises request if enabled
// - Result signed, zero near minus 25 degrees
// - Modulators run at input clock over four
// - Decimator averages bitstream into 24-bit words
// - Codes saturate at 262144, converters identical
// ---------------------------------------------------------------------

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
`define MIRQ_ADDR_MODE 6'h09
`define MIRQ_ADDR_EN 6'h0a
`define MIRQ_ADDR_FLAGS 6'h0b
`define MIRQ_ADDR_RC 6'h0c
`define MIRQ_ADDR_TEMP 6'h26
`define MIRQ_MODE_RST 16'h0000
`define MIRQ_EN_RST 16'h0000
`define MIRQ_FLAGS_RST 16'h0000
`define MIRQ_ZERO16 16'h0000
`define MIRQ_TEMP_RST 8'h00
`define MIRQ_TEMP_PAD 8'h00
`define MIRQ_MODE_TEMP_BIT 5
`define MIRQ_FLAG_TEMP_BIT 5

// ---------------------------------------------------------------------
// Serial frame
// ---------------------------------------------------------------------
`define MIRQ_BIT_ZERO 5'h00
`define MIRQ_BIT_ONE 5'h01
`define MIRQ_CMD_LAST 5'h07
`define MIRQ_DATA_FIRST 5'h08
`define MIRQ_DATA_LAST 5'h17
`define MIRQ_BIT_MAX 5'h1f

// ---------------------------------------------------------------------
// Timing and converter scaling
// ---------------------------------------------------------------------
`define MIRQ_DIV_ONE 2'h1
`define MIRQ_DIV_LAST 2'h3
`define MIRQ_CLK_DIV 4
`define MIRQ_TEMP_MOD_CYC 24
`define MIRQ_TEMP_WAIT (`MIRQ_TEMP_MOD_CYC * `MIRQ_CLK_DIV)
`define MIRQ_TEMP_CNT_W 7
`define MIRQ_TEMP_CNT_INIT 7'(`MIRQ_TEMP_WAIT - 1)
`define MIRQ_TEMP_CNT_ZERO 7'h00
`define MIRQ_TEMP_CNT_ONE 7'h01
`define MIRQ_DEC_LOG2 9
`define MIRQ_DEC_SHIFT 9
`define MIRQ_ACC_ZERO 11'h000
`define MIRQ_ACC_ONE 11'h001
`define MIRQ_WIN_ONE 9'h001
`define MIRQ_WIN_LAST 9'h1ff
`define MIRQ_CONV_FS 24'h040000
`define MIRQ_CONV_RST 24'h000000
`define MIRQ_TEMP_SHIFT 11
`define MIRQ_TEMP_MAX 8'h7f

// ---------------------------------------------------------------------
// Synchroniser lanes
// ---------------------------------------------------------------------
`define MIRQ_SY_W 6
`define MIRQ_SY_CMD 0
`define MIRQ_SY_WR 1
`define MIRQ_SY_DONE 2
`define MIRQ_SY_CS 3
`define MIRQ_SY_M1 4
`define MIRQ_SY_M2 5
`define MIRQ_SY_RST 6'h00
`endif

// ### design/mirq_pkg.sv
// Types shared by the meter interrupt and temperature block
package mirq_pkg;
    // Command byte as received on the serial link
    typedef struct packed {
        logic wr;
        logic rsv;
        logic [5:0] addr;
    } mirq_cmd_s;

    // Temperature measurement sequence
    typedef enum logic [1:0] {
        T_IDLE,
        T_ARMED,
        T_CONV
    } mirq_temp_e;
endpackage : mirq_pkg

// ### design/mirq_top.sv
// Interrupt status, temperature trigger and converter decimation
`include "mirq_defs.svh"

// ---------------------------------------------------------------------
// Three-stage synchroniser
// ---------------------------------------------------------------------
module mirq_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Foreign levels in, stage two and three out
    input wire logic [W-1:0] din,
    output logic [W-1:0] s2,
    output logic [W-1:0] s3
);
    logic [W-1:0] s1;

    // First stage is read by the second stage only
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end
endmodule : mirq_sync

// ---------------------------------------------------------------------
// Boxcar decimator, one per converter
// ---------------------------------------------------------------------
module mirq_decim
    import mirq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Modulator bitstream
    input wire logic sampleEn,
    input wire logic bitIn,
    // Averaged word
    output logic [23:0] code
);
    localparam logic signed [23:0] FsPos = `MIRQ_CONV_FS;
    logic [`MIRQ_DEC_LOG2-1:0] win_r;
    logic signed [`MIRQ_DEC_LOG2+1:0] acc_r;
    logic signed [`MIRQ_DEC_LOG2+1:0] accNxt;
    logic signed [23:0] scaled;
    logic winEnd;

    // Ones count up, zeros count down; full window maps to full scale
    always_comb begin
        accNxt = bitIn ? acc_r + `MIRQ_ACC_ONE : acc_r - `MIRQ_ACC_ONE;
        scaled = 24'(accNxt) <<< `MIRQ_DEC_SHIFT;
        winEnd = sampleEn && (win_r == `MIRQ_WIN_LAST);
    end

    // Window counter and accumulator
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            win_r <= '0;
            acc_r <= `MIRQ_ACC_ZERO;
        end else if (sampleEn) begin
            win_r <= win_r + `MIRQ_WIN_ONE;
            acc_r <= winEnd ? `MIRQ_ACC_ZERO : accNxt;
        end
    end

    // Saturated output word, kept for a whole window
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            code <= `MIRQ_CONV_RST;
        end else if (winEnd) begin
            if (scaled > FsPos) begin
                code <= FsPos;
            end else if (scaled < -FsPos) begin
                code <= -FsPos;
            end else begin
                code <= scaled;
            end
        end
    end

    AST_CONV_SAT: assert property (@(posedge clk) disable iff (sys_rst)
        ($signed(code) <= FsPos) && ($signed(code) >= -FsPos))
        else $error("converter code beyond full scale");
    AST_CONV_WINDOW: assert property (@(posedge clk) disable iff (sys_rst)
        $changed(code) |-> $past(winEnd))
        else $error("converter code changed mid window");
endmodule : mirq_decim

// ---------------------------------------------------------------------
// Top level
// ---------------------------------------------------------------------
module mirq_top
    import mirq_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Serial link
    input wire logic sclk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdoO,
    output logic sdoOe,
    // Open-drain request pin
    output logic irqO,
    output logic irqOe,
    // Metering events and line crossing
    input wire logic [15:0] eventIn,
    input wire logic zeroCross,
    // Converters
    input wire logic modBit1,
    input wire logic modBit2,
    output logic modClk,
    output logic sensorRoute,
    output logic [23:0] conv1Code,
    output logic [23:0] conv2Code
);
    localparam int TempWait = `MIRQ_TEMP_WAIT;

    // -----------------------------------------------------------------
    // Link domain
    // -----------------------------------------------------------------
    logic [4:0] bitCnt_r;
    logic [14:0] shIn_r;
    mirq_cmd_s cmd_r;
    logic [15:0] wrData_r;
    logic cmdTog_r;
    logic wrTog_r;
    logic doneTog_r;
    logic sdo_r;
    logic [15:0] rdHold_r;

    // Bit counter; the frame's own select ends it
    always_ff @(negedge sclk or posedge csN or posedge sys_rst) begin
        if (csN || sys_rst) begin
            bitCnt_r <= `MIRQ_BIT_ZERO;
            shIn_r <= '0;
        end else begin
            if (bitCnt_r != `MIRQ_BIT_MAX) begin
                bitCnt_r <= bitCnt_r + `MIRQ_BIT_ONE;
            end
            shIn_r <= {shIn_r[13:0], sdi};
        end
    end

    // Read command and write word, each announced by a toggle
    always_ff @(negedge sclk or posedge sys_rst) begin
        if (sys_rst) begin
            cmd_r <= '0;
            wrData_r <= '0;
            cmdTog_r <= 1'b0;
            wrTog_r <= 1'b0;
            doneTog_r <= 1'b0;
        end else if (!csN) begin
            if (bitCnt_r == `MIRQ_CMD_LAST) begin
                cmd_r <= mirq_cmd_s'({shIn_r[6:0], sdi});
                if (!shIn_r[6]) begin
                    cmdTog_r <= !cmdTog_r;
                end
            end
            if (bitCnt_r == `MIRQ_DATA_LAST) begin
                if (cmd_r.wr) begin
                    wrData_r <= {shIn_r, sdi};
                    wrTog_r <= !wrTog_r;
                end else if (cmd_r.addr == `MIRQ_ADDR_RC) begin
                    doneTog_r <= !doneTog_r;
                end
            end
        end
    end

    // Read word out MSB first; holding word is quiet by then
    always_ff @(posedge sclk or posedge csN or posedge sys_rst) begin
        if (csN || sys_rst) begin
            sdo_r <= 1'b0;
        end else if (bitCnt_r >= `MIRQ_DATA_FIRST && bitCnt_r <= `MIRQ_DATA_LAST) begin
            sdo_r <= rdHold_r[4'(`MIRQ_DATA_LAST - bitCnt_r)];
        end else begin
            sdo_r <= 1'b0;
        end
    end
    assign sdoO = sdo_r;

    // -----------------------------------------------------------------
    // Crossing into the system domain
    // -----------------------------------------------------------------
    logic [`MIRQ_SY_W-1:0] syS2;
    logic [`MIRQ_SY_W-1:0] syS3;
    logic [`MIRQ_SY_W-1:0] filt_r;
    logic [`MIRQ_SY_W-1:0] seen_r;
    logic [`MIRQ_SY_W-1:0] chg;

    mirq_sync #(.W(`MIRQ_SY_W)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({modBit2, modBit1, !csN, doneTog_r, wrTog_r, cmdTog_r}),
        .s2(syS2),
        .s3(syS3)
    );

    // Take a level only once stages two and three agree
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            filt_r <= `MIRQ_SY_RST;
            seen_r <= `MIRQ_SY_RST;
        end else begin
            filt_r <= (syS2 & syS3) | (filt_r & (syS2 ^ syS3));
            seen_r <= filt_r;
        end
    end
    assign chg = filt_r ^ seen_r;

    logic cmdEv;
    logic wrEv;
    logic doneEv;
    logic csEnd;
    logic rcEv;
    assign cmdEv = chg[`MIRQ_SY_CMD];
    assign wrEv = chg[`MIRQ_SY_WR];
    assign doneEv = chg[`MIRQ_SY_DONE];
    assign csEnd = chg[`MIRQ_SY_CS] && !filt_r[`MIRQ_SY_CS];
    assign rcEv = cmdEv && (cmd_r.addr == `MIRQ_ADDR_RC);

    // -----------------------------------------------------------------
    // Clock divider for the modulators
    // -----------------------------------------------------------------
    logic [1:0] div_r;
    logic modClk_r;
    logic sampleEn;

    // Input clock over four; a sample is taken once per period
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            div_r <= '0;
            modClk_r <= 1'b0;
        end else begin
            div_r <= div_r + `MIRQ_DIV_ONE;
            modClk_r <= div_r[1];
        end
    end
    assign sampleEn = (div_r == `MIRQ_DIV_LAST);
    assign modClk = modClk_r;

    // Identical chains so equal inputs give equal codes
    mirq_decim u_dec1 (
        .clk(clk),
        .sys_rst(sys_rst),
        .sampleEn(sampleEn),
        .bitIn(filt_r[`MIRQ_SY_M1]),
        .code(conv1Code)
    );
    mirq_decim u_dec2 (
        .clk(clk),
        .sys_rst(sys_rst),
        .sampleEn(sampleEn),
        .bitIn(filt_r[`MIRQ_SY_M2]),
        .code(conv2Code)
    );

    // -----------------------------------------------------------------
    // Temperature sequence
    // -----------------------------------------------------------------
    mirq_temp_e tState_r;
    logic [`MIRQ_TEMP_CNT_W-1:0] tCnt_r;
    logic sensorRoute_r;
    logic [7:0] temp_r;
    logic [15:0] mode_r;
    logic tDoneEv;
    logic signed [23:0] tScaled;

    assign tDoneEv = (tState_r == T_CONV) && (tCnt_r == `MIRQ_TEMP_CNT_ZERO);
    assign tScaled = $signed(conv1Code) >>> `MIRQ_TEMP_SHIFT;

    // Armed by the mode bit, started by the next line crossing
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tState_r <= T_IDLE;
            tCnt_r <= `MIRQ_TEMP_CNT_ZERO;
            sensorRoute_r <= 1'b0;
        end else begin
            case (tState_r)
                T_IDLE: begin
                    if (mode_r[`MIRQ_MODE_TEMP_BIT]) begin
                        tState_r <= T_ARMED;
                    end
                end
                T_ARMED: begin
                    if (!mode_r[`MIRQ_MODE_TEMP_BIT]) begin
                        tState_r <= T_IDLE;
                    end else if (zeroCross) begin
                        tState_r <= T_CONV;
                        tCnt_r <= `MIRQ_TEMP_CNT_INIT;
                        sensorRoute_r <= 1'b1;
                    end
                end
                T_CONV: begin
                    if (tDoneEv) begin
                        tState_r <= T_IDLE;
                        sensorRoute_r <= 1'b0;
                    end else begin
                        tCnt_r <= tCnt_r - `MIRQ_TEMP_CNT_ONE;
                    end
                end
                default: begin
                    tState_r <= T_IDLE;
                end
            endcase
        end
    end
    assign sensorRoute = sensorRoute_r;

    // Signed result; coarse shift clamps to the byte range
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            temp_r <= `MIRQ_TEMP_RST;
        end else if (tDoneEv) begin
            temp_r <= (tScaled > $signed(`MIRQ_TEMP_MAX)) ? `MIRQ_TEMP_MAX
                                                        : tScaled[7:0];
        end
    end

    // Mode: software write wins, arm bit drops after a conversion
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mode_r <= `MIRQ_MODE_RST;
        end else if (wrEv && cmd_r.addr == `MIRQ_ADDR_MODE) begin
            mode_r <= wrData_r;
        end else if (tDoneEv) begin
            mode_r[`MIRQ_MODE_TEMP_BIT] <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Status, enable and request
    // -----------------------------------------------------------------
    logic [15:0] flags_r;
    logic [15:0] en_r;
    logic hold_r;
    logic irqOe_r;
    logic [15:0] evAll;
    logic [15:0] flagsNxt;
    logic [15:0] enNxt;
    logic holdNxt;

    always_comb begin
        evAll = eventIn;
        evAll[`MIRQ_FLAG_TEMP_BIT] = eventIn[`MIRQ_FLAG_TEMP_BIT] | tDoneEv;
        // Clear drops the old flags but never a new event
        flagsNxt = (rcEv ? `MIRQ_ZERO16 : flags_r) | evAll;
        enNxt = (wrEv && cmd_r.addr == `MIRQ_ADDR_EN) ? wrData_r : en_r;
        if (rcEv) begin
            holdNxt = 1'b1;
        end else if (doneEv || csEnd) begin
            holdNxt = 1'b0;
        end else begin
            holdNxt = hold_r;
        end
    end

    // Registers of the status path
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            flags_r <= `MIRQ_FLAGS_RST;
            en_r <= `MIRQ_EN_RST;
            hold_r <= 1'b0;
            irqOe_r <= 1'b0;
        end else begin
            flags_r <= flagsNxt;
            en_r <= enNxt;
            hold_r <= holdNxt;
            irqOe_r <= !holdNxt && |(flagsNxt & enNxt);
        end
    end
    assign irqOe = irqOe_r;
    assign irqO = 1'b0;

    // Read word captured as the command lands
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdHold_r <= `MIRQ_ZERO16;
        end else if (cmdEv && !cmd_r.wr) begin
            case (cmd_r.addr)
                `MIRQ_ADDR_MODE: rdHold_r <= mode_r;
                `MIRQ_ADDR_EN: rdHold_r <= en_r;
                `MIRQ_ADDR_FLAGS: rdHold_r <= flags_r;
                `MIRQ_ADDR_RC: rdHold_r <= flags_r;
                `MIRQ_ADDR_TEMP: rdHold_r <= {temp_r, `MIRQ_TEMP_PAD};
                default: rdHold_r <= `MIRQ_ZERO16;
            endcase
        end
    end

    // Data output enabled while the frame is selected
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sdoOe <= 1'b0;
        end else begin
            sdoOe <= filt_r[`MIRQ_SY_CS];
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    default clocking cbSys @(posedge clk); endclocking
    default disable iff (sys_rst);

    sequence sConvStart;
        (tState_r == T_ARMED) && mode_r[`MIRQ_MODE_TEMP_BIT] && zeroCross;
    endsequence
    sequence sReadClear;
        rcEv ##1 hold_r;
    endsequence

    AST_FLAG_SET: assert property ((eventIn != `MIRQ_ZERO16) |=>
        ((flags_r & $past(eventIn)) == $past(eventIn)))
        else $error("event did not set its flag");
    AST_IRQ_LEVEL: assert property (!hold_r |->
        (irqOe_r == |(flags_r & en_r)))
        else $error("request pin disagrees with enabled flags");
    AST_MASKED_KEPT: assert property (((eventIn & ~en_r) != `MIRQ_ZERO16) |=>
        (((flags_r | $past(en_r)) & $past(eventIn)) == $past(eventIn))
        && (hold_r || (irqOe_r == |(flags_r & en_r))))
        else $error("masked event lost or leaked");
    AST_RC_CLEAR: assert property (rcEv && (evAll == `MIRQ_ZERO16) |=>
        (flags_r == `MIRQ_ZERO16) && (rdHold_r == $past(flags_r)))
        else $error("read-clear did not return and clear");
    AST_RC_KEEP: assert property (rcEv |=> (flags_r == $past(evAll)))
        else $error("event during read-clear was lost");
    AST_RC_RELEASE: assert property (sReadClear |-> !irqOe_r)
        else $error("request not released on read-clear");
    AST_HOLD_HIGH: assert property (hold_r |-> !irqOe_r)
        else $error("request low during status transfer");
    AST_RELOAD: assert property (hold_r && doneEv && (|(flagsNxt & enNxt)) |=>
        irqOe_r && !hold_r)
        else $error("pending request not reasserted");
    AST_TEMP_TIME: assert property (sConvStart |=> sensorRoute_r ##(TempWait-1)
        tDoneEv ##1 (flags_r[`MIRQ_FLAG_TEMP_BIT] && !sensorRoute_r))
        else $error("temperature result not on time");
    AST_TEMP_IRQ: assert property (tDoneEv && en_r[`MIRQ_FLAG_TEMP_BIT] && !holdNxt
        && !wrEv |=> irqOe_r)
        else $error("temperature done did not raise request");
    AST_ARM: assert property ((tState_r == T_IDLE) && mode_r[`MIRQ_MODE_TEMP_BIT] |=>
        (tState_r == T_ARMED))
        else $error("mode bit did not arm measurement");
    AST_MOD_CLK: assert property ($rose(modClk_r) |->
        ##2 $fell(modClk_r) ##2 $rose(modClk_r))
        else $error("modulator clock not a quarter rate");
endmodule : mirq_top

// ### sim/mirq_host.sv
// Host model: serial master frames and request line watch
module mirq_host (
    // Serial link
    output logic sclk,
    output logic csN,
    output logic sdi,
    input wire logic sdoO,
    input wire logic sdoOe,
    // Request pin
    input wire logic irqOe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sdoLast = 1'b0;
    logic holdBroken = 1'b0;
    logic irqEdge = 1'b0;
    // Released data line shows inverse of its last level
    wire sdoPin = sdoOe ? sdoO : ~sdoLast;
    initial begin
        sclk = 1'b1;
        csN = 1'b1;
        sdi = 1'b0;
    end
    always @(posedge sclk) if (sdoOe) sdoLast <= sdoO;
    // Falling edge of the pin latches a service request
    always @(posedge irqOe) irqEdge = 1'b1;
    // One whole frame; clock stands high outside frames
    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rd);
        logic [23:0] sh;
        sh = {cmd, wd};
        rd = 16'h0000;
        holdBroken = 1'b0;
        if (cmd == 8'h0c) irqEdge = 1'b0;
        sdi = sh[23];
        csN = 1'b0;
        #48;
        for (int i = 0; i < 24; i++) begin
            sclk = 1'b0;
            #16;
            // Room for the read word to cross into the clk domain
            if (i == 7) #48;
            sclk = 1'b1;
            #8;
            // Bit 15 leaves on the rising edge right after the command
            if (i >= 7 && i < 23) rd = {rd[14:0], sdoPin};
            if (i >= 10 && i < 23 && irqOe) holdBroken = 1'b1;
            if (i < 23) sdi = sh[22 - i];
            #8;
        end
        #16;
        csN = 1'b1;
        #64;
    endtask : xfer
endmodule : mirq_host

// ### sim/meter_irq_and_temp_sensing_test.sv
// Self-checking bench for the meter interrupt and temperature block
`include "mirq_defs.svh"
module meter_irq_and_temp_sensing_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic sys_rst = 1'b0;
    logic sclk, csN, sdi, sdoO, sdoOe, irqO, irqOe, modClk, sensorRoute;
    logic zeroCross = 1'b0;
    logic modBit1 = 1'b1;
    logic modBit2 = 1'b1;
    logic [15:0] eventIn = 16'h0000;
    logic [15:0] rdw;
    logic [23:0] conv1Code, conv2Code;
    int fails = 0;
    int n_checks = 0;
    always #2.5 clk = ~clk;
    mirq_top mirq_top_inst (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .csN(csN), .sdi(sdi),
        .sdoO(sdoO), .sdoOe(sdoOe), .irqO(irqO), .irqOe(irqOe), .eventIn(eventIn),
        .zeroCross(zeroCross), .modBit1(modBit1), .modBit2(modBit2), .modClk(modClk),
        .sensorRoute(sensorRoute), .conv1Code(conv1Code), .conv2Code(conv2Code));
    mirq_host mirq_host_inst (.sclk(sclk), .csN(csN), .sdi(sdi), .sdoO(sdoO), .sdoOe(sdoOe),
        .irqOe(irqOe));
    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    task automatic cmpVal(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmpVal
    task automatic cmpBit(input string what, input logic exp, input logic got);
        cmpVal(what, {23'h0, exp}, {23'h0, got});
    endtask : cmpBit
    task automatic regWr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] x;
        mirq_host_inst.xfer({2'b10, a}, d, x);
    endtask : regWr
    task automatic regRd(input logic [5:0] a, output logic [15:0] d);
        mirq_host_inst.xfer({2'b00, a}, 16'h0000, d);
    endtask : regRd
    // Inputs move on the falling clk edge only
    task automatic pulse(input logic [15:0] ev, input logic zc);
        @(negedge clk);
        eventIn = ev;
        zeroCross = zc;
        @(negedge clk);
        eventIn = 16'h0000;
        zeroCross = 1'b0;
    endtask : pulse
    // -----------------------------------------------------------------
    // Scenarios
    // -----------------------------------------------------------------
    task automatic tFlags();
        regRd(`MIRQ_ADDR_EN, rdw);
        cmpVal("enable reset", 24'h0, {8'h0, rdw});
        pulse(16'h0008, 1'b0);
        @(negedge clk);
        cmpBit("irq masked", 1'b0, irqOe);
        regRd(`MIRQ_ADDR_FLAGS, rdw);
        cmpVal("flags", 24'h0008, {8'h0, rdw});
        regWr(`MIRQ_ADDR_EN, 16'h000a);
        cmpBit("irq enabled", 1'b1, irqOe);
        regRd(6'h3f, rdw);
        cmpVal("unmapped", 24'h0, {8'h0, rdw});
    endtask : tFlags
    // Event lands in the data phase of a read-with-clear
    task automatic tReadClear();
        fork
            mirq_host_inst.xfer({2'b00, `MIRQ_ADDR_RC}, 16'h0000, rdw);
            begin
                #520;
                pulse(16'h0002, 1'b0);
            end
        join
        cmpVal("rc word", 24'h0008, {8'h0, rdw});
        cmpBit("irq held", 1'b0, mirq_host_inst.holdBroken);
        cmpBit("irq pending", 1'b1, irqOe);
        cmpBit("host edge", 1'b1, mirq_host_inst.irqEdge);
        regRd(`MIRQ_ADDR_RC, rdw);
        cmpVal("rc pending", 24'h0002, {8'h0, rdw});
        cmpBit("irq cleared", 1'b0, irqOe);
    endtask : tReadClear
    // Full-scale ones stream in both converters
    task automatic tConv();
        realtime t0;
        @(posedge modClk);
        t0 = $realtime;
        @(posedge modClk);
        cmpVal("mod period", 24'd20, 24'($rtoi($realtime - t0)));
        repeat (4200) @(negedge clk);
        cmpVal("conv1", 24'h040000, conv1Code);
        cmpVal("conv2", 24'h040000, conv2Code);
    endtask : tConv
    task automatic tTemp();
        int n;
        regWr(`MIRQ_ADDR_MODE, 16'h0020);
        regWr(`MIRQ_ADDR_EN, 16'h0020);
        cmpBit("route idle", 1'b0, sensorRoute);
        pulse(16'h0000, 1'b1);
        cmpBit("route on", 1'b1, sensorRoute);
        n = 0;
        while (sensorRoute === 1'b1 && n < 200) begin
            n++;
            @(negedge clk);
        end
        cmpVal("conv span", 24'd96, 24'(n));
        cmpBit("temp irq", 1'b1, irqOe);
        regRd(`MIRQ_ADDR_FLAGS, rdw);
        cmpVal("temp flag", 24'h0020, {8'h0, rdw});
        regRd(`MIRQ_ADDR_TEMP, rdw);
        cmpVal("temp code", 24'h7f00, {8'h0, rdw});
        // Arm bit drops by itself once the conversion is done
        regRd(`MIRQ_ADDR_MODE, rdw);
        cmpVal("mode arm", 24'h0, {8'h0, rdw});
    endtask : tTemp
    // -----------------------------------------------------------------
    // Run control
    // -----------------------------------------------------------------
    task automatic print_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    // Hang guard, well past the expected run of about 30 us
    initial begin
        #150000;
        fails++;
        print_verdict();
    end
    initial begin
        // Raised as an edge so the link-side flops reset too
        #1 sys_rst = 1'b1;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (10) @(negedge clk);
        cmpBit("irq reset", 1'b0, irqOe);
        cmpBit("irq level", 1'b0, irqO);
        tFlags();
        tReadClear();
        tConv();
        tTemp();
        print_verdict();
    end
endmodule : meter_irq_and_temp_sensing_test
